// ===== shared/dac_cfg_pkg.sv
// Shared constants, field layout and types of the dual converter control block
package dac_cfg_pkg;

	// Data path and register bus widths
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam int ERR_W  = 3;

	// Register offsets, one 16-bit register each
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_MISC   = 4'h1;
	localparam logic [3:0] REG_OFS_A  = 4'h2;
	localparam logic [3:0] REG_OFS_B  = 4'h3;
	localparam logic [3:0] REG_XFER   = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h5;
	localparam logic [3:0] REG_MASK   = 4'h6;
	localparam logic [3:0] REG_STATE  = 4'h7;

	// Control register field positions
	localparam int CTL_DELAY   = 0;  // Two bits, output delay
	localparam int CTL_CLKDLY  = 2;  // Three bits, clock buffer stages
	localparam int CTL_MODE    = 5;  // Two bits, channel mode
	localparam int CTL_SLEEP_A = 7;
	localparam int CTL_SLEEP_B = 8;
	localparam int CTL_OFS_EN  = 9;
	localparam int CTL_WIRE4   = 10; // One selects the four wire port
	localparam int CTL_SYNC_SW = 11; // One selects software sync
	localparam int CTL_SW_SYNC = 12; // Software sync level
	localparam int CTL_TCHECK  = 13; // Input timing check enable
	localparam int CTL_SELF    = 14; // Core self check enable

	// Miscellaneous register field positions
	localparam int MSC_GAIN_A  = 0;  // Four bits
	localparam int MSC_GAIN_B  = 4;  // Four bits
	localparam int MSC_FIFO_OF = 8;  // Three bits, signed -4 to +3
	localparam int MSC_SOUT    = 11; // Three bits, serial out source

	// Error flag positions, shared by status and mask
	localparam int ERR_SELF = 0;
	localparam int ERR_FIFO = 1;
	localparam int ERR_SH   = 2;

	// Values after reset
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] MISC_RST = 16'h0000;
	localparam logic [15:0] OFS_RST  = 16'h0000;
	localparam logic [2:0]  MASK_RST = 3'h0;

	// Channel modes
	localparam logic [1:0] MODE_DUAL = 2'h0;
	localparam logic [1:0] MODE_ILV  = 2'h1;

	// Timing check patterns
	localparam logic [15:0] PAT_HI = 16'hAAAA;
	localparam logic [15:0] PAT_LO = 16'h5555;

	// FIFO geometry; the pointer reload is centred on half depth
	localparam int         FIFO_DEPTH = 8;
	localparam logic [3:0] FIFO_HALF  = 4'h4;

	// Sample rate relative to the link word rate
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int LINK_PERIOD_PS = 64000;
	localparam int SAMPLE_DIV     =
		(LINK_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// One sample for each channel
	typedef struct packed {
		logic [15:0] a;
		logic [15:0] b;
	} pair_t;

	// Interleaved word pairing state
	typedef enum logic [1:0] {
		PAIR_FIRST  = 2'b01,
		PAIR_SECOND = 2'b10
	} pair_state_t;

endpackage : dac_cfg_pkg

// ===== src/dual_dac_digital_config.sv
// Digital configuration, data path and error logic of the dual converter
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module dual_dac_digital_config #(
	parameter int SAMPLE_DIV = dac_cfg_pkg::SAMPLE_DIV
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic        link_clk,
	input  wire logic [15:0] din_a,
	input  wire logic [15:0] din_b,
	input  wire logic        sync_pin,
	input  wire logic        self_check_fail,
	output logic      [15:0] dac_a,
	output logic      [15:0] dac_b,
	output logic             dac_valid,
	output logic             sleep_a,
	output logic             sleep_b,
	output logic      [3:0]  gain_a,
	output logic      [3:0]  gain_b,
	output logic             irq,
	output logic             ser_out,
	output logic             ser_out_oe_n,
	output logic             shared_out,
	output logic             shared_oe_n
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	// True when a received word is one of the two check patterns
	function automatic logic is_pattern(input logic [15:0] w);
		is_pattern = (w == dac_cfg_pkg::PAT_HI) || (w == dac_cfg_pkg::PAT_LO);
	endfunction : is_pattern

	// Signed add that clamps at the extreme codes
	function automatic logic [15:0] sat_add(input logic [15:0] x,
	                                        input logic [15:0] y);
		logic [16:0] s;
		s = {x[15], x} + {y[15], y};
		if (s[16] != s[15]) begin
			sat_add = s[16] ? 16'h8000 : 16'h7FFF;
		end else begin
			sat_add = s[15:0];
		end
	endfunction : sat_add

	////////////////////////////////////////////////////////////////////////
	// Register state

	logic [15:0] ctrl;          // Mode and enable bits
	logic [15:0] misc;          // Gains, FIFO offset, serial out source
	logic [15:0] ofs_a_stage;   // Offsets as written by software
	logic [15:0] ofs_b_stage;
	logic [15:0] ofs_a_work;    // Offsets used by the adders
	logic [15:0] ofs_b_work;
	logic [2:0]  err_flags;     // Sticky error flags
	logic [2:0]  err_mask;      // One keeps the matching flag off the interrupt

	// Write decode
	wire wr_ctrl   = wr && (addr == dac_cfg_pkg::REG_CTRL);
	wire wr_misc   = wr && (addr == dac_cfg_pkg::REG_MISC);
	wire wr_ofs_a  = wr && (addr == dac_cfg_pkg::REG_OFS_A);
	wire wr_ofs_b  = wr && (addr == dac_cfg_pkg::REG_OFS_B);
	wire wr_xfer   = wr && (addr == dac_cfg_pkg::REG_XFER);
	wire wr_status = wr && (addr == dac_cfg_pkg::REG_STATUS);
	wire wr_mask   = wr && (addr == dac_cfg_pkg::REG_MASK);

	// Control fields
	wire [1:0] data_delay = ctrl[dac_cfg_pkg::CTL_DELAY +: 2];
	wire [2:0] clk_delay  = ctrl[dac_cfg_pkg::CTL_CLKDLY +: 3];
	wire [1:0] chan_mode  = ctrl[dac_cfg_pkg::CTL_MODE +: 2];
	wire       ofs_en     = ctrl[dac_cfg_pkg::CTL_OFS_EN];
	wire       wire4      = ctrl[dac_cfg_pkg::CTL_WIRE4];
	wire       sync_sw    = ctrl[dac_cfg_pkg::CTL_SYNC_SW];
	wire       sw_sync    = ctrl[dac_cfg_pkg::CTL_SW_SYNC];
	wire       tcheck     = ctrl[dac_cfg_pkg::CTL_TCHECK];
	wire       self_en    = ctrl[dac_cfg_pkg::CTL_SELF];
	wire [2:0] fifo_ofs   = misc[dac_cfg_pkg::MSC_FIFO_OF +: 3];
	wire [2:0] sout_sel   = misc[dac_cfg_pkg::MSC_SOUT +: 3];

	// Mode decode; codes above interleaved mean single channel
	wire mode_single = chan_mode[1];
	wire mode_ilv    = (chan_mode == dac_cfg_pkg::MODE_ILV);

	// Control and staged offset registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl        <= dac_cfg_pkg::CTRL_RST;
			misc        <= dac_cfg_pkg::MISC_RST;
			ofs_a_stage <= dac_cfg_pkg::OFS_RST;
			ofs_b_stage <= dac_cfg_pkg::OFS_RST;
			err_mask    <= dac_cfg_pkg::MASK_RST;
		end else begin
			if (wr_ctrl)  ctrl        <= wdata;
			if (wr_misc)  misc        <= wdata;
			if (wr_ofs_a) ofs_a_stage <= wdata;
			if (wr_ofs_b) ofs_b_stage <= wdata;
			if (wr_mask)  err_mask    <= wdata[2:0];
		end
	end

	// Working offsets change only on the transfer strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			ofs_a_work <= dac_cfg_pkg::OFS_RST;
			ofs_b_work <= dac_cfg_pkg::OFS_RST;
		end else if (wr_xfer) begin
			ofs_a_work <= ofs_a_stage;
			ofs_b_work <= ofs_b_stage;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, a level moves once two and three agree

	logic [2:0]  link_s;        // Link clock samples
	logic [2:0]  sync_s;        // External sync samples
	logic        link_lvl;      // Filtered link clock
	logic        sync_lvl;      // Filtered external sync
	logic [15:0] da_q [3];      // Data pipelines matched to the clock path
	logic [15:0] db_q [3];

	// Sampling flops
	always_ff @(posedge mclk) begin
		if (rst) begin
			link_s   <= 3'h0;
			sync_s   <= 3'h0;
			link_lvl <= 1'b0;
			sync_lvl <= 1'b0;
		end else begin
			link_s <= {link_s[1:0], link_clk};
			sync_s <= {sync_s[1:0], sync_pin};
			if (link_s[1] == link_s[2]) link_lvl <= link_s[2];
			if (sync_s[1] == sync_s[2]) sync_lvl <= sync_s[2];
		end
	end

	// Data stages, same depth as the clock path
	always_ff @(posedge mclk) begin
		da_q[0] <= din_a;
		db_q[0] <= din_b;
		da_q[1] <= da_q[0];
		db_q[1] <= db_q[0];
		da_q[2] <= da_q[1];
		db_q[2] <= db_q[1];
	end

	// Link rising edge, then a chain of delay stages
	logic       link_lvl_q;     // Previous filtered link level
	logic [6:0] edge_sr;        // Buffer stage chain
	wire        link_edge = link_lvl && !link_lvl_q;
	wire [7:0]  edge_taps = {edge_sr, link_edge};
	wire        push      = edge_taps[clk_delay];

	always_ff @(posedge mclk) begin
		if (rst) begin
			link_lvl_q <= 1'b0;
			edge_sr    <= 7'h00;
		end else begin
			link_lvl_q <= link_lvl;
			edge_sr    <= {edge_sr[5:0], link_edge};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sync source and transmit enable

	logic sel_lvl_q;                                                // Edge finder
	wire  sel_lvl  = sync_sw ? sw_sync : sync_lvl;
	wire  sync_ev  = sel_lvl && !sel_lvl_q;
	wire  tx_en    = sel_lvl;

	always_ff @(posedge mclk) begin
		if (rst) sel_lvl_q <= 1'b0;
		else     sel_lvl_q <= sel_lvl;
	end

	////////////////////////////////////////////////////////////////////////
	// Word pairing; interleaved mode takes A then B from the A bus

	dac_cfg_pkg::pair_state_t pair_st;
	logic [15:0]              hold_a;   // First word of an interleaved pair
	wire  ilv_second = (pair_st == dac_cfg_pkg::PAIR_SECOND);
	wire  word_push  = push && (!mode_ilv || ilv_second);
	wire  dac_cfg_pkg::pair_t in_pair =
		mode_ilv ? {hold_a, da_q[2]} : {da_q[2], db_q[2]};  // A in high half

	always_ff @(posedge mclk) begin
		if (rst) begin
			pair_st <= dac_cfg_pkg::PAIR_FIRST;
			hold_a  <= 16'h0000;
		end else if (push) begin
			case (pair_st)
				dac_cfg_pkg::PAIR_FIRST: begin
					hold_a <= da_q[2];
					if (mode_ilv) pair_st <= dac_cfg_pkg::PAIR_SECOND;
				end
				dac_cfg_pkg::PAIR_SECOND: begin
					pair_st <= dac_cfg_pkg::PAIR_FIRST;
				end
				default: begin
					pair_st <= dac_cfg_pkg::PAIR_FIRST;
				end
			endcase
		end
	end

	// Pattern test on each received word; B bus only counts when in use
	wire sh_bad = push && tcheck && (!is_pattern(da_q[2]) ||
		(!mode_ilv && !mode_single && !is_pattern(db_q[2])));

	////////////////////////////////////////////////////////////////////////
	// FIFO between link words and converter samples

	localparam int PW = $clog2(dac_cfg_pkg::FIFO_DEPTH);

	dac_cfg_pkg::pair_t mem [dac_cfg_pkg::FIFO_DEPTH];
	logic [PW-1:0]      wr_ptr;
	logic [PW-1:0]      rd_ptr;
	logic [PW:0]        fill;
	logic [7:0]         div_cnt;    // Sample rate divider
	logic               sample_en;  // One cycle per output sample

	wire [3:0] fill_init = dac_cfg_pkg::FIFO_HALF - {fifo_ofs[2], fifo_ofs};
	wire full     = (fill == 4'(dac_cfg_pkg::FIFO_DEPTH));
	wire empty    = (fill == 4'h0);
	wire pop      = sample_en && tx_en;
	wire pop_ok   = pop && !empty;
	// A word that meets a reload to a full position is dropped, so the
	// fill count can never pass the depth
	wire push_ok  = word_push &&
		(sync_ev ? !fill_init[PW] : (!full || pop_ok));
	wire overrun  = (word_push && !push_ok) || (pop && empty);

	// Sample rate divider
	always_ff @(posedge mclk) begin
		if (rst) begin
			div_cnt   <= 8'h00;
			sample_en <= 1'b0;
		end else begin
			sample_en <= (div_cnt == 8'(SAMPLE_DIV - 1));
			div_cnt   <= (div_cnt == 8'(SAMPLE_DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
		end
	end

	// Storage
	always_ff @(posedge mclk) begin
		if (push_ok) mem[wr_ptr] <= in_pair;
	end

	// Pointers; a sync event reloads the read side from the offset
	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end else begin
			if (push_ok) wr_ptr <= wr_ptr + PW'(1);
			if (sync_ev) begin
				rd_ptr <= wr_ptr - fill_init[PW-1:0];
				fill   <= fill_init + {3'h0, push_ok};
			end else begin
				if (pop_ok) rd_ptr <= rd_ptr + PW'(1);
				fill <= fill + {3'h0, push_ok} - {3'h0, pop_ok};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Routing, offset and output delay

	dac_cfg_pkg::pair_t dly [4];            // Delay line, stage 0 newest
	wire dac_cfg_pkg::pair_t head = pop_ok ? mem[rd_ptr] : '0;
	wire [15:0] path_b = mode_single ? 16'h0000 : head.b;  // A only
	wire [15:0] ofs_a  = ofs_en ? ofs_a_work : 16'h0000;
	wire [15:0] ofs_b  = ofs_en ? ofs_b_work : 16'h0000;
	wire dac_cfg_pkg::pair_t proc =
		'{a: sat_add(head.a, ofs_a), b: sat_add(path_b, ofs_b)};

	// Delay line and output stage, one step per sample
	always_ff @(posedge mclk) begin
		if (rst) begin
			dly       <= '{default: '0};
			dac_a     <= 16'h0000;
			dac_b     <= 16'h0000;
			dac_valid <= 1'b0;
		end else begin
			dac_valid <= sample_en;
			if (sample_en) begin
				dly[0] <= proc;
				dly[1] <= dly[0];
				dly[2] <= dly[1];
				dly[3] <= dly[2];
				dac_a  <= dly[data_delay].a;
				dac_b  <= dly[data_delay].b;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Error flags and interrupt

	wire [2:0] err_set  = {sh_bad, overrun, self_en && self_check_fail};
	wire [2:0] err_keep = wr_status ? wdata[2:0] : 3'h7;
	wire [2:0] err_show = err_flags & ~err_mask;

	// Writing zero clears a flag; a new event in that cycle wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			err_flags <= 3'h0;
			irq       <= 1'b0;
		end else begin
			err_flags <= (err_flags & err_keep) | err_set;
			irq       <= |err_show;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin outputs and serial port drive

	wire [7:0] sout_src = {3'h0, err_flags[dac_cfg_pkg::ERR_SH],
		err_flags[dac_cfg_pkg::ERR_FIFO], err_flags[dac_cfg_pkg::ERR_SELF],
		tx_en, irq};
	wire sout_bit = sout_src[sout_sel];

	// Registered pin drive
	always_ff @(posedge mclk) begin
		if (rst) begin
			sleep_a      <= 1'b0;
			sleep_b      <= 1'b0;
			gain_a       <= 4'h0;
			gain_b       <= 4'h0;
			ser_out      <= 1'b0;
			shared_out   <= 1'b0;
			ser_out_oe_n <= 1'b1;
			shared_oe_n  <= 1'b1;
		end else begin
			sleep_a      <= ctrl[dac_cfg_pkg::CTL_SLEEP_A];
			sleep_b      <= ctrl[dac_cfg_pkg::CTL_SLEEP_B];
			gain_a       <= misc[dac_cfg_pkg::MSC_GAIN_A +: 4];
			gain_b       <= misc[dac_cfg_pkg::MSC_GAIN_B +: 4];
			ser_out      <= sout_bit;
			shared_out   <= sout_bit;
			ser_out_oe_n <= !wire4;
			shared_oe_n  <= wire4;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port, data in the cycle after the strobe

	wire [15:0] rd_mux =
		(addr == dac_cfg_pkg::REG_CTRL)   ? ctrl :
		(addr == dac_cfg_pkg::REG_MISC)   ? misc :
		(addr == dac_cfg_pkg::REG_OFS_A)  ? ofs_a_stage :
		(addr == dac_cfg_pkg::REG_OFS_B)  ? ofs_b_stage :
		(addr == dac_cfg_pkg::REG_STATUS) ? {13'h0, err_flags} :
		(addr == dac_cfg_pkg::REG_MASK)   ? {13'h0, err_mask} :
		(addr == dac_cfg_pkg::REG_STATE)  ? {9'h0, fill, sel_lvl, link_lvl, tx_en} :
		16'h0000;

	always_ff @(posedge mclk) begin
		if (rst)     rdata <= 16'h0000;
		else if (rd) rdata <= rd_mux;
		else         rdata <= 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Offset written to the stage, then transferred
	sequence s_stage_a;
		wr_ofs_a ##1 !wr_ofs_a ##1 wr_xfer;
	endsequence

	a_offset_transfer: assert property (
		s_stage_a |=> ofs_a_work == ofs_a_stage)
		else $error("Working offset A not loaded by transfer");

	a_offset_staged: assert property (!wr_xfer |=> $stable(ofs_a_work))
		else $error("Working offset A changed without transfer");

	a_flag_sticky: assert property (err_flags[0] && !wr_status |=> err_flags[0])
		else $error("Self check flag dropped without a clear");

	a_fifo_error: assert property (overrun |=> err_flags[dac_cfg_pkg::ERR_FIFO])
		else $error("Overrun did not set the FIFO flag");

	a_pattern_error: assert property (sh_bad |=> err_flags[dac_cfg_pkg::ERR_SH])
		else $error("Bad check word did not set its flag");

	a_irq_mask: assert property (##1 irq == |$past(err_flags & ~err_mask))
		else $error("Interrupt disagrees with masked flags");

	a_single_no_sleep: assert property (mode_single && !ctrl[8] ##1 1 |-> !sleep_b)
		else $error("Channel B asleep without its own bit");

	a_soft_sync_only: assert property (sync_sw |-> tx_en == sw_sync)
		else $error("External sync used while software sync selected");

	a_wire_mode: assert property (wr_ctrl ##1 1 ##1 1 |-> ser_out_oe_n == !$past(wdata[10], 2))
		else $error("Serial pin enable does not follow wire mode");

endmodule : dual_dac_digital_config

// ===== bench/link_source.sv
// Behavioural parallel data source that feeds the converter input buses
`timescale 1ns/1ps

module link_source (
	input  wire logic [15:0] word_a,
	input  wire logic [15:0] word_b,
	output logic             link_clk,
	output logic      [15:0] din_a,
	output logic      [15:0] din_b
);

	////////////////////////////////////////////////////////////////////////
	// Word clock, 64 ns period, runs freely like a real source
	initial begin
		link_clk = 1'b0;
		din_a    = 16'h0000;
		din_b    = 16'h0000;
	end

	// Half period toggle
	always #32 link_clk = ~link_clk;

	////////////////////////////////////////////////////////////////////////
	// Data changes on the falling edge, so it stands half a period either
	// side of the rising edge that the block samples
	always @(negedge link_clk) begin
		din_a <= word_a;
		din_b <= word_b;
	end

endmodule : link_source

// ===== bench/tb_top.sv
// Self-checking bench for the dual converter control block
`timescale 1ns/1ps

module tb_top;
	logic        mclk;            // Sample clock
	logic        rst;             // Synchronous reset
	logic [3:0]  addr;            // Register bus
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        link_clk;        // Source side
	logic [15:0] din_a;
	logic [15:0] din_b;
	logic        sync_pin;
	logic        self_check_fail;
	logic [15:0] dac_a;           // Converter side
	logic [15:0] dac_b;
	logic        dac_valid;
	logic        sleep_a;
	logic        sleep_b;
	logic [3:0]  gain_a;
	logic [3:0]  gain_b;
	logic        irq;
	logic        ser_out;
	logic        ser_out_oe_n;
	logic        shared_out;
	logic        shared_oe_n;
	logic [15:0] word_a;          // Words the source sends
	logic [15:0] word_b;
	logic [15:0] rv;              // Last read value
	logic [31:0] rows [7];        // {addr, data, expected pins}
	int          error_cnt;
	int          tests_run;
	int          cycles;          // Watchdog count
	int          n_steps;         // Output steps counted
	wire  [11:0] pins = {sleep_a, sleep_b, gain_a, gain_b,
		ser_out_oe_n, shared_oe_n};

	////////////////////////////////////////////////////////////////////////
	// Design and data source
	dual_dac_digital_config dut (.mclk, .rst, .addr, .wdata, .wr, .rd,
		.rdata, .link_clk, .din_a, .din_b, .sync_pin, .self_check_fail,
		.dac_a, .dac_b, .dac_valid, .sleep_a, .sleep_b, .gain_a, .gain_b,
		.irq, .ser_out, .ser_out_oe_n, .shared_out, .shared_oe_n);

	link_source src (.word_a, .word_b, .link_clk, .din_a, .din_b);

	////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	always #2.5 mclk = ~mclk;

	// A hang counts as a mismatch
	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (cycles == 10000) begin
			error_cnt = error_cnt + 1;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One cycle write strobe
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wreg

	// Read data stands only in the cycle after the strobe
	task automatic rreg(input logic [3:0] a);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask : rreg

	// Let edges pass, then sample settled outputs
	task automatic pass_cycles(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : pass_cycles

	// Count output steps until dac_b shows v; gives up after 200 cycles
	task automatic steps_until(input logic [15:0] v, output int n);
		n = 0;
		for (int k = 0; k < 200 && dac_b !== v; k++) begin
			@(posedge mclk);
			#1;
			if (dac_valid) n++;
		end
	endtask : steps_until

	task automatic report_and_stop;
		$display("checks %0d, errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		sync_pin = 1'b0;
		self_check_fail = 1'b0;
		word_a = 16'h1000;
		word_b = 16'h2000;
		error_cnt = 0;
		tests_run = 0;
		cycles = 0;
		n_steps = 0;
		// Pin table rows: sleep, single mode, interleaved, wires, gains
		rows = '{32'h0008_0802, 32'h0014_0402, 32'h0004_0002,
			32'h0002_0002, 32'h0040_0001, 32'h100F_30FD, 32'h1000_0001};
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		pass_cycles(2);
		check({4'h0, pins}, 16'h0002);
		rreg(dac_cfg_pkg::REG_CTRL);
		check(rv, dac_cfg_pkg::CTRL_RST);
		rreg(dac_cfg_pkg::REG_MISC);
		check(rv, dac_cfg_pkg::MISC_RST);
		// Ordinary cases: each write shows on the pins and reads back
		for (int i = 0; i < 7; i++) begin
			wreg(rows[i][31:28], rows[i][27:12]);
			pass_cycles(3);
			check({4'h0, pins}, {4'h0, rows[i][11:0]});
			rreg(rows[i][31:28]);
			check(rv, rows[i][27:12]);
		end
		// Unmapped place and the strobe register read zero
		wreg(4'h8, 16'hFFFF);
		rreg(4'h8);
		check(rv, 16'h0000);
		rreg(dac_cfg_pkg::REG_XFER);
		check(rv, 16'h0000);
		// No pops while transmit is off: the buffer overruns
		wreg(dac_cfg_pkg::REG_CTRL, 16'h0800);
		pass_cycles(300);
		rreg(dac_cfg_pkg::REG_STATUS);
		check(rv & 16'h0002, 16'h0002);
		check({15'h0, irq}, 16'h0001);
		wreg(dac_cfg_pkg::REG_MASK, 16'h0002);
		pass_cycles(3);
		check({15'h0, irq}, 16'h0000);
		// Software sync starts the flow with a staged offset on A
		wreg(dac_cfg_pkg::REG_OFS_A, 16'h0100);
		wreg(dac_cfg_pkg::REG_XFER, 16'h0000);
		wreg(dac_cfg_pkg::REG_CTRL, 16'h1A00);
		pass_cycles(200);
		wreg(dac_cfg_pkg::REG_STATUS, 16'h0000);
		rreg(dac_cfg_pkg::REG_STATUS);
		check(rv & 16'h0002, 16'h0000);
		check(dac_a, 16'h1100);
		check(dac_b, 16'h2000);
		// A staged value has no effect until the transfer strobe
		wreg(dac_cfg_pkg::REG_OFS_B, 16'h0010);
		pass_cycles(100);
		check(dac_b, 16'h2000);
		wreg(dac_cfg_pkg::REG_XFER, 16'h0000);
		pass_cycles(100);
		check(dac_b, 16'h2010);
		// Output delay: a new offset shows 2 + delay steps after transfer
		for (int d = 3; d >= 0; d -= 3) begin
			wreg(dac_cfg_pkg::REG_CTRL, 16'h1A00 | 16'(d));
			pass_cycles(100);
			wreg(dac_cfg_pkg::REG_OFS_B, 16'h0020 - 16'(d));
			wreg(dac_cfg_pkg::REG_XFER, 16'h0000);
			steps_until(16'h2020 - 16'(d), n_steps);
			check(16'(n_steps), 16'(2 + d));
		end
		// Sum beyond the positive limit clamps
		word_a <= 16'h7000;
		wreg(dac_cfg_pkg::REG_OFS_A, 16'h2000);
		wreg(dac_cfg_pkg::REG_XFER, 16'h0000);
		pass_cycles(200);
		check(dac_a, 16'h7FFF);
		// Serial out carries transmit enable
		wreg(dac_cfg_pkg::REG_MISC, 16'h0800);
		pass_cycles(3);
		check({15'h0, ser_out}, 16'h0001);
		check({15'h0, shared_out}, 16'h0001);
		// Single mode: A only, B stays awake
		wreg(dac_cfg_pkg::REG_CTRL, 16'h1840);
		pass_cycles(200);
		check(dac_a, 16'h7000);
		check(dac_b, 16'h0000);
		check({15'h0, sleep_b}, 16'h0000);
		// Software sync low gates transmit; the external pin is ignored
		wreg(dac_cfg_pkg::REG_CTRL, 16'h0840);
		sync_pin <= 1'b1;
		pass_cycles(200);
		check(dac_a, 16'h0000);
		check({15'h0, ser_out}, 16'h0000);
		rreg(dac_cfg_pkg::REG_STATE);
		check(rv & 16'h0004, 16'h0000);
		sync_pin <= 1'b0;
		// Timing check: patterns pass, any other word sets the flag
		word_a <= 16'hAAAA;
		word_b <= 16'h5555;
		// FIFO offset of -4 leaves the buffer full after the sync reload
		wreg(dac_cfg_pkg::REG_MISC, 16'h0C00);
		wreg(dac_cfg_pkg::REG_CTRL, 16'h3800);
		rreg(dac_cfg_pkg::REG_STATE);
		check(rv & 16'h0078, 16'h0040);
		pass_cycles(200);
		wreg(dac_cfg_pkg::REG_STATUS, 16'h0000);
		pass_cycles(100);
		rreg(dac_cfg_pkg::REG_STATUS);
		check(rv & 16'h0004, 16'h0000);
		word_b <= 16'h1234;
		pass_cycles(100);
		rreg(dac_cfg_pkg::REG_STATUS);
		check(rv & 16'h0004, 16'h0004);
		// Self check failure, masking and clearing
		wreg(dac_cfg_pkg::REG_MASK, 16'h0006);
		wreg(dac_cfg_pkg::REG_CTRL, 16'h4000);
		self_check_fail <= 1'b1;
		pass_cycles(5);
		self_check_fail <= 1'b0;
		rreg(dac_cfg_pkg::REG_STATUS);
		check(rv & 16'h0001, 16'h0001);
		check({15'h0, irq}, 16'h0001);
		wreg(dac_cfg_pkg::REG_MASK, 16'h0007);
		pass_cycles(3);
		check({15'h0, irq}, 16'h0000);
		wreg(dac_cfg_pkg::REG_STATUS, 16'h0000);
		rreg(dac_cfg_pkg::REG_STATUS);
		check(rv & 16'h0001, 16'h0000);
		// Mid-run reset returns pins and registers to their reset values
		@(posedge mclk);
		rst <= 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		pass_cycles(2);
		check({4'h0, pins}, 16'h0002);
		check({15'h0, irq}, 16'h0000);
		rreg(dac_cfg_pkg::REG_MASK);
		check(rv, {13'h0, dac_cfg_pkg::MASK_RST});
		report_and_stop();
	end

endmodule : tb_top
